// ---- rtl/underload_autoreset_regs.vh ----
/*
 * Register map, field layout and timing constants of the underload
 * supervisor and automatic fault reset block.
 * Assumes a 25 MHz system clock and a 16-bit register bus.
 */
`ifndef UNDERLOAD_AUTORESET_REGS_VH
`define UNDERLOAD_AUTORESET_REGS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define REG_CTRL        4'h0
`define REG_UL_TIME     4'h1
`define REG_AR_COUNT    4'h2
`define REG_AR_WINDOW   4'h3
`define REG_AR_DELAY    4'h4
`define REG_RATED_FREQ  4'h5
`define REG_STATUS      4'h6
`define REG_IRQ_STAT    4'h7
`define REG_IRQ_MASK    4'h8

// ****************************************************************
// Control fields
// ****************************************************************
`define CTRL_ACTION_LO  0
`define CTRL_ACTION_HI  1
`define CTRL_CURVE_LO   2
`define CTRL_CURVE_HI   4
`define CTRL_EN_OC      5
`define CTRL_EN_OV      6
`define CTRL_EN_UV      7
`define CTRL_EN_AI      8

// ****************************************************************
// Codes and reset values
// ****************************************************************
`define ACT_OFF         2'h0
`define ACT_FAULT       2'h1
`define ACT_WARN        2'h2
`define CTRL_RESET      16'h0000
`define UL_TIME_RESET   16'h0014
`define AR_COUNT_RESET  16'h0005
`define AR_WINDOW_RESET 16'h001E
`define AR_DELAY_RESET  16'h0000
`define RATED_FREQ_RST  16'h01F4

// ****************************************************************
// Timing: frequencies in 0.1 Hz, times in 0.1 s ticks
// ****************************************************************
`define FREQ_FLOOR      16'h0032
`define TICK_NS         100000000
`define CLK_NS          40

`endif

// ---- rtl/tick_timer.v ----
/*
 * Free-running time base: one-cycle pulse every TICK_CYCLES clocks.
 * Assumes a single clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
module tick_timer #(
  parameter integer TICK_CYCLES = 2500000
) (
  input  wire clk,
  input  wire nrst,
  output reg  tick
);
  reg [31:0] count;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= 32'h0000_0000;
      tick  <= 1'b0;
    end else if (count == TICK_CYCLES - 1) begin
      count <= 32'h0000_0000;
      tick  <= 1'b1;
    end else begin
      count <= count + 32'h0000_0001;
      tick  <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/load_curve.v ----
/*
 * Underload limit lookup: torque threshold for the chosen curve at the
 * present output frequency. Torque in per mille of rated torque.
 * Assumes frequencies share one unit (0.1 Hz).
 */
`timescale 1ns/100ps
`default_nettype none
module load_curve (
  input  wire [2:0]  curve,
  input  wire [15:0] out_freq,
  input  wire [15:0] rated_freq,
  output reg  [15:0] limit
);
  // Curves 0..2 rise to a peak at rated frequency then hold; 3 and 4
  // are flat. Peak levels are plain defaults.
  reg [31:0] ramp;
  reg [15:0] peak;

  always @* begin
    ramp  = 32'h0000_0000;
    peak  = 16'h0000;
    limit = 16'h0000;
    case (curve)
      3'h0:    peak = 16'h0064;
      3'h1:    peak = 16'h00C8;
      3'h2:    peak = 16'h012C;
      3'h3:    peak = 16'h0064;
      default: peak = 16'h00C8;
    endcase
    if (curve > 3'h2) begin
      limit = peak;
    end else if (out_freq >= rated_freq || rated_freq == 16'h0000) begin
      limit = peak;
    end else begin
      ramp  = (peak * out_freq) / rated_freq;
      limit = ramp[15:0];
    end
  end
endmodule
`default_nettype wire

// ---- rtl/underload_autoreset.v ----
/*
 * Underload supervisor and automatic fault reset engine.
 * Assumes torque, frequency and fault inputs come from logic on clk,
 * except the panel and external reset pins, which are synchronised.
 */
// Contract
// - Torque below selected load curve qualifies underload.
// - Underload acts only after condition outlasts the time limit.
// - Inhibited unless frequency exceeds 10% rated and 5 Hz.
// - Action 0 off, 1 fault with coast, 2 warning.
// - Five curves; first three peak at rated frequency.
// - Autoreset only overcurrent, overvoltage, undervoltage, input loss.
// - Allowance used up: block autoreset until manual reset.
// - Count autoresets over window, compare against allowed count.
// - Wait reset delay before autoreset; zero means immediate.
// - Overcurrent enable gates automatic clearing.
// - Overvoltage enable gates automatic clearing.
// - Undervoltage enable gates automatic clearing.
// - Input-loss enable gates automatic clearing.
// - Input-loss autoreset may restart after long stop: hazard.
`timescale 1ns/100ps
`default_nettype none
`include "underload_autoreset_regs.vh"
module underload_autoreset #(
  parameter integer TICK_CYCLES = `TICK_NS / `CLK_NS,
  parameter integer HIST_DEPTH  = 16
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire [3:0]  addr,
  input  wire [15:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [15:0] rdata,
  input  wire [15:0] motor_torque,
  input  wire [15:0] output_frequency,
  input  wire        fault_overcurrent,
  input  wire        fault_bus_high,
  input  wire        fault_bus_low,
  input  wire        fault_input_loss,
  input  wire        fault_other,
  input  wire        panel_reset_pin,
  input  wire        ext_reset_pin,
  output wire        drive_tripped,
  output wire        coast_stop,
  output reg         underload_warning,
  output wire        autoreset_pulse,
  output wire        irq
);
  // ****************************************************************
  // Registers
  // ****************************************************************
  reg  [15:0] ctrl;
  reg  [15:0] ul_time;
  reg  [15:0] allowed_autoreset_count;
  reg  [15:0] autoreset_window_time;
  reg  [15:0] ar_delay;
  reg  [15:0] motor_rated_frequency;
  reg  [3:0]  irq_stat;
  reg  [3:0]  irq_mask;
  // Times count ticks of the free-running base, so a setting has up to
  // one tick of jitter at its start.
  wire        tick;
  wire [15:0] curve_limit;

  wire [1:0] action = ctrl[`CTRL_ACTION_HI:`CTRL_ACTION_LO];
  wire       autoclear_overcurrent_en = ctrl[`CTRL_EN_OC];
  wire       autoclear_bus_high_en    = ctrl[`CTRL_EN_OV];
  wire       autoclear_bus_low_en     = ctrl[`CTRL_EN_UV];
  wire       autoclear_input_loss_en  = ctrl[`CTRL_EN_AI];

  tick_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk  (clk),
    .nrst (nrst),
    .tick (tick)
  );

  load_curve u_curve (
    .curve      (ctrl[`CTRL_CURVE_HI:`CTRL_CURVE_LO]),
    .out_freq   (output_frequency),
    .rated_freq (motor_rated_frequency),
    .limit      (curve_limit)
  );

  // ****************************************************************
  // Manual reset pins, two-stage synchronisers
  // ****************************************************************
  reg [1:0] panel_sync;
  reg [1:0] ext_sync;
  reg       manual_prev;
  wire      manual_level = panel_sync[1] | ext_sync[1];
  // Only the rising edge acts, so a button held down does not keep
  // clearing faults that come back while it is pressed.
  wire      manual_reset = manual_level & ~manual_prev;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      panel_sync  <= 2'h0;
      ext_sync    <= 2'h0;
      manual_prev <= 1'b0;
    end else begin
      panel_sync  <= {panel_sync[0], panel_reset_pin};
      ext_sync    <= {ext_sync[0], ext_reset_pin};
      manual_prev <= manual_level;
    end
  end

  // ****************************************************************
  // Underload detection
  // ****************************************************************
  reg  [15:0] ul_count;
  reg         ul_trip;
  // Ten times the frequency is built from two shifts, so the check
  // needs no multiplier.
  wire [19:0] freq_x10 = {1'b0, output_frequency, 3'h0} +
                         {3'h0, output_frequency, 1'b0};
  wire freq_ok = (output_frequency > `FREQ_FLOOR) &&
                 (freq_x10 > {4'h0, motor_rated_frequency});
  wire below = (motor_torque < curve_limit) && freq_ok &&
               (action != `ACT_OFF);
  wire ul_active = below && (ul_count > ul_time);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ul_count          <= 16'h0000;
      ul_trip           <= 1'b0;
      underload_warning <= 1'b0;
    end else begin
      // The counter saturates rather than wrapping, so a long underload
      // never starts to look short again.
      // persistence timer
      if (!below) begin
        ul_count <= 16'h0000;
      end else if (tick && ul_count != 16'hFFFF) begin
        ul_count <= ul_count + 16'h0001;
      end
      underload_warning <= ul_active && (action == `ACT_WARN);
      if (ul_active && action == `ACT_FAULT) begin
        ul_trip <= 1'b1;
      end else if (manual_reset) begin
        ul_trip <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Fault latching and automatic reset engine
  // ****************************************************************
  localparam [3:0] ST_IDLE    = 4'h1;
  localparam [3:0] ST_DELAY   = 4'h2;
  localparam [3:0] ST_BLOCKED = 4'h4;
  localparam [3:0] ST_MANUAL  = 4'h8;

  reg  [3:0]  state;
  reg  [3:0]  fault_latch;
  reg         other_latch;
  reg  [15:0] delay_count;
  reg  [31:0] now;
  // Each granted autoreset stamps the time base into a ring of HIST_DEPTH
  // entries. Allowed counts above HIST_DEPTH cannot be policed, because
  // the oldest stamps are overwritten first.
  reg  [31:0] hist [0:HIST_DEPTH-1];
  reg  [HIST_DEPTH-1:0] hist_valid;
  reg  [3:0]  hist_wp;
  reg  [15:0] in_window;
  integer     i;

  // only four fault types are auto-resettable
  wire [3:0] fault_in = {fault_input_loss, fault_bus_low,
                         fault_bus_high, fault_overcurrent};
  wire [3:0] fault_en = {autoclear_input_loss_en, autoclear_bus_low_en,
                         autoclear_bus_high_en, autoclear_overcurrent_en};
  wire any_fault   = (|fault_latch) | other_latch;
  wire auto_ok     = (|fault_latch) && !other_latch &&
                     ((fault_latch & ~fault_en) == 4'h0);
  // The window count holds earlier grants only; the added one stands for
  // the reset that is being asked for now.
  // count inside sliding window, current one included
  wire allowance   = (in_window + 16'h0001) <= allowed_autoreset_count;
  wire delay_done  = delay_count >= ar_delay;

  always @* begin
    in_window = 16'h0000;
    for (i = 0; i < HIST_DEPTH; i = i + 1) begin
      if (hist_valid[i] &&
          (now - hist[i]) < {16'h0000, autoreset_window_time}) begin
        in_window = in_window + 16'h0001;
      end
    end
  end

  // The pulse also needs auto_ok: a disabled or foreign fault that lands
  // while the delay runs must not be swept away with the others.
  assign autoreset_pulse = (state == ST_DELAY) && auto_ok && delay_done &&
                           allowance;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state       <= ST_IDLE;
      fault_latch <= 4'h0;
      other_latch <= 1'b0;
      delay_count <= 16'h0000;
      now         <= 32'h0000_0000;
      hist_valid  <= {HIST_DEPTH{1'b0}};
      hist_wp     <= 4'h0;
    end else begin
      if (tick) begin
        now <= now + 32'h0000_0001;
      end
      case (state)
        ST_IDLE: begin
          // Cleared here so that every new fault waits the full delay.
          delay_count <= 16'h0000;
          if (any_fault) begin
            state <= auto_ok ? ST_DELAY : ST_MANUAL;
          end
        end
        ST_DELAY: begin
          if (!auto_ok) begin
            state <= ST_MANUAL;
          end else if (delay_done) begin
            if (allowance) begin
              // input loss may restart the motor here
              // The restart follows the input's return however long the
              // stop lasted; the integrator must gate it where unsafe.
              fault_latch         <= 4'h0;
              hist[hist_wp]       <= now;
              hist_valid[hist_wp] <= 1'b1;
              hist_wp             <= hist_wp + 4'h1;
              state               <= ST_IDLE;
            end else begin
              state <= ST_BLOCKED;
            end
          end else if (tick) begin
            delay_count <= delay_count + 16'h0001;
          end
        end
        ST_BLOCKED, ST_MANUAL: begin
          // Both states behave alike; they differ so that software can tell
          // a used-up allowance from a fault that needs a person.
          // stay stopped until manual reset
          if (manual_reset) begin
            fault_latch <= 4'h0;
            other_latch <= 1'b0;
            state       <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
      // New faults win over clears in the same cycle.
      fault_latch <= autoreset_pulse ||
                     (manual_reset && state[3:2] != 2'h0) ?
                     fault_in : (fault_latch | fault_in);
      other_latch <= (manual_reset && state[3:2] != 2'h0) ?
                     fault_other : (other_latch | fault_other);
    end
  end

  // The stop is always a coast: no ramp is tried once a trip is latched.
  // Both outputs are kept so the power stage and the panel wire apart.
  assign drive_tripped = any_fault | ul_trip;
  assign coast_stop    = drive_tripped;

  // ****************************************************************
  // Register bus and interrupts
  // ****************************************************************
  // Status word: [12] foreign fault, [11:8] resettable faults, [7:4]
  // engine state, [2] warning, [1] underload trip, [0] underload active.
  wire [15:0] status_word = {3'h0, other_latch, fault_latch, state, 1'b0,
                             underload_warning, ul_trip, ul_active};
  // Events: 0 underload active, 1 warning, 2 autoreset, 3 blocked.
  // Level causes such as the blocked state set their bit again on every
  // cycle, so a read clears them only once the cause has gone.
  wire [3:0] events = {state == ST_BLOCKED, autoreset_pulse,
                       underload_warning, ul_active};
  wire       stat_rd = rd && addr == `REG_IRQ_STAT;
  assign irq = |(irq_stat & irq_mask);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl                    <= `CTRL_RESET;
      ul_time                 <= `UL_TIME_RESET;
      allowed_autoreset_count <= `AR_COUNT_RESET;
      autoreset_window_time   <= `AR_WINDOW_RESET;
      ar_delay                <= `AR_DELAY_RESET;
      motor_rated_frequency   <= `RATED_FREQ_RST;
      irq_mask                <= 4'h0;
      irq_stat                <= 4'h0;
      rdata                   <= 16'h0000;
    end else begin
      irq_stat <= (stat_rd ? 4'h0 : irq_stat) | events;
      // Writes to the status words and to unused offsets fall through
      // every branch and are dropped.
      if (wr) begin
        if (addr == `REG_CTRL) begin
          ctrl <= wdata;
        end else if (addr == `REG_UL_TIME) begin
          ul_time <= wdata;
        end else if (addr == `REG_AR_COUNT) begin
          allowed_autoreset_count <= wdata;
        end else if (addr == `REG_AR_WINDOW) begin
          autoreset_window_time <= wdata;
        end else if (addr == `REG_AR_DELAY) begin
          ar_delay <= wdata;
        end else if (addr == `REG_RATED_FREQ) begin
          motor_rated_frequency <= wdata;
        end else if (addr == `REG_IRQ_MASK) begin
          irq_mask <= wdata[3:0];
        end
      end
      rdata <= 16'h0000;
      if (rd) begin
        if (addr == `REG_CTRL) begin
          rdata <= ctrl;
        end else if (addr == `REG_UL_TIME) begin
          rdata <= ul_time;
        end else if (addr == `REG_AR_COUNT) begin
          rdata <= allowed_autoreset_count;
        end else if (addr == `REG_AR_WINDOW) begin
          rdata <= autoreset_window_time;
        end else if (addr == `REG_AR_DELAY) begin
          rdata <= ar_delay;
        end else if (addr == `REG_RATED_FREQ) begin
          rdata <= motor_rated_frequency;
        end else if (addr == `REG_STATUS) begin
          rdata <= status_word;
        end else if (addr == `REG_IRQ_STAT) begin
          rdata <= {12'h000, irq_stat};
        end else if (addr == `REG_IRQ_MASK) begin
          rdata <= {12'h000, irq_mask};
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/ul_ar_checker_assertions.sv ----
/* Port checker for underload_autoreset.
   Assumes it is bound to the top module from the bench. */
`timescale 1ns/100ps
`default_nettype none
`include "underload_autoreset_regs.vh"
module ul_ar_checker (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic [15:0] output_frequency,
  input wire logic        fault_other,
  input wire logic        panel_reset_pin,
  input wire logic        ext_reset_pin,
  input wire logic        drive_tripped,
  input wire logic        coast_stop,
  input wire logic        underload_warning,
  input wire logic        autoreset_pulse
);
  // ****************
  // Shadow settings
  // ****************
  logic [15:0]      ctl;
  logic [15:0]      rated;
  wire logic [1:0]  act = ctl[1:0];
  wire logic [19:0] f10 = {4'h0, output_frequency} * 20'h0000A;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Settings are tracked from the bus, the only view of them we have.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl   <= `CTRL_RESET;
      rated <= `RATED_FREQ_RST;
    end else if (wr && addr == `REG_CTRL) begin
      ctl <= wdata;
    end else if (wr && addr == `REG_RATED_FREQ) begin
      rated <= wdata;
    end
  end
  // ****************
  // Properties
  // ****************
  property p_coast; coast_stop == drive_tripped; endproperty
  a_coast: assert property (p_coast)
    else $error("coast and trip differ");
  property p_warn;
    underload_warning |-> act == `ACT_WARN || $past(act) == `ACT_WARN;
  endproperty
  a_warn: assert property (p_warn)
    else $error("warning without warning action");
  property p_other; fault_other |=> drive_tripped [*8]; endproperty
  a_other: assert property (p_other)
    else $error("other fault not held");
  property p_ena; autoreset_pulse |-> ctl[8:5] != 4'h0; endproperty
  a_ena: assert property (p_ena)
    else $error("autoreset with no enable");
  property p_one; autoreset_pulse |=> !autoreset_pulse; endproperty
  a_one: assert property (p_one)
    else $error("autoreset pulse too long");
  property p_freq;
    $rose(underload_warning) |-> $past(output_frequency) > `FREQ_FLOOR
      && $past(f10) > {4'h0, rated};
  endproperty
  a_freq: assert property (p_freq)
    else $error("underload at low frequency");
  property p_man;
    $rose(panel_reset_pin) || $rose(ext_reset_pin) |-> ##[1:6] !drive_tripped;
  endproperty
  a_man: assert property (p_man)
    else $error("manual reset ignored");
  property p_idle; !$past(rd) |-> rdata == 16'h0000; endproperty
  a_idle: assert property (p_idle)
    else $error("read data outside read slot");
endmodule
`default_nettype wire

// ---- verif/drive_partner.sv ----
/* Far side model: fault detectors and the two reset buttons.
   Assumes the bench raises each request for one cycle. */
`timescale 1ns/100ps
`default_nettype none
module drive_partner (
  input  wire logic       clk,
  input  wire logic [4:0] fault_req,
  input  wire logic       reset_req,
  input  wire logic       use_ext,
  output logic      [4:0] fault_line,
  output logic            panel_pin,
  output logic            ext_pin
);
  // ****************
  // Detectors
  // ****************
  logic [4:0] line_q = 5'h00;
  logic [2:0] hold   = 3'h0;
  always @(posedge clk) begin
    line_q <= fault_req;
  end
  assign fault_line = line_q;
  always @(posedge clk) begin
    if (reset_req)
      hold <= 3'h4;
    else if (hold != 3'h0)
      hold <= hold - 3'h1;
  end
  // A press lasts several cycles so it outlives the pin synchroniser.
  assign panel_pin = (hold != 3'h0) && !use_ext;
  assign ext_pin   = (hold != 3'h0) && use_ext;
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
/* Directed bench for underload_autoreset.
   Assumes the register header and a 10 cycle tick. */
`timescale 1ns/100ps
`default_nettype none
`include "underload_autoreset_regs.vh"
module tb_top;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] motor_torque = 16'h03E8;
  logic [15:0] output_frequency = 16'h012C;
  logic [4:0]  fault_req = 5'h00;
  logic        reset_req = 1'b0;
  logic        use_ext = 1'b0;
  int          errors = 0;
  int          n_compared = 0;
  wire logic [15:0] rdata;
  wire logic [4:0]  fl;
  wire logic        pnl, ext, trip, coast, warn, arp, irq;
  wire logic [2:0]  flags = {irq, warn, trip};
  logic [15:0] rst_val [6] = '{`CTRL_RESET, `UL_TIME_RESET, `AR_COUNT_RESET,
    `AR_WINDOW_RESET, `AR_DELAY_RESET, `RATED_FREQ_RST};
  initial begin
    forever #20 clk = ~clk;
  end
  underload_autoreset #(.TICK_CYCLES(10)) DUT (.clk(clk), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .motor_torque(motor_torque), .output_frequency(output_frequency),
    .fault_overcurrent(fl[0]), .fault_bus_high(fl[1]),
    .fault_bus_low(fl[2]), .fault_input_loss(fl[3]), .fault_other(fl[4]),
    .panel_reset_pin(pnl), .ext_reset_pin(ext), .drive_tripped(trip),
    .coast_stop(coast), .underload_warning(warn),
    .autoreset_pulse(arp), .irq(irq));
  drive_partner u_far (.clk(clk), .fault_req(fault_req),
    .reset_req(reset_req), .use_ext(use_ext), .fault_line(fl),
    .panel_pin(pnl), .ext_pin(ext));
  // ****************
  // Tasks
  // ****************
  task automatic print_verdict;
    $display("errors=%0d compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
    @(posedge clk);
  endtask
  // Flags are read live at the falling edge, clear of update races.
  task automatic flag_chk(input int i, input logic e);
    @(negedge clk);
    chk({15'h0000, flags[i]}, {15'h0000, e});
    @(posedge clk);
  endtask
  task automatic see(input int n, input logic e);
    logic hit;
    hit = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if (arp === 1'b1)
        hit = 1'b1;
    end
    chk({15'h0000, hit}, {15'h0000, e});
    @(posedge clk);
  endtask
  task automatic fault(input int i);
    fault_req <= 5'h01 << i;
    @(posedge clk);
    fault_req <= 5'h00;
  endtask
  task automatic man_rst(input logic x);
    use_ext   <= x;
    reset_req <= 1'b1;
    @(posedge clk);
    reset_req <= 1'b0;
    repeat (10) @(posedge clk);
  endtask
  task automatic ul_run(input logic [15:0] c, f, t, input logic [1:0] e);
    motor_torque <= 16'h03E8;
    man_rst(1'b0);
    wr_reg(`REG_CTRL, c);
    output_frequency <= f;
    motor_torque     <= t;
    repeat (80) @(posedge clk);
    @(negedge clk);
    chk({14'h0000, trip, warn}, {14'h0000, e});
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    #2000000;
    errors++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      rd_chk(i[3:0], rst_val[i]);
    end
    rd_chk(4'hF, 16'h0000);
    rd_chk(`REG_IRQ_STAT, 16'h0000);
    wr_reg(`REG_STATUS, 16'hFFFF);
    rd_chk(`REG_STATUS, 16'h0010);
    wr_reg(`REG_AR_COUNT, 16'h0002);
    wr_reg(`REG_AR_WINDOW, 16'h0064);
    wr_reg(`REG_CTRL, 16'h0020);
    fault(0);
    see(6, 1'b1);
    fault(0);
    see(6, 1'b1);
    fault(0);
    see(20, 1'b0);
    flag_chk(0, 1'b1);
    man_rst(1'b1);
    flag_chk(0, 1'b0);
    repeat (1100) @(posedge clk);
    fault(0);
    see(6, 1'b1);
    wr_reg(`REG_AR_WINDOW, 16'h0003);
    wr_reg(`REG_AR_COUNT, 16'h0008);
    wr_reg(`REG_AR_DELAY, 16'h0002);
    for (int i = 0; i < 4; i++) begin
      wr_reg(`REG_CTRL, 16'h01E0 & ~(16'h0020 << i));
      fault(i);
      see(40, 1'b0);
      man_rst(1'b0);
      wr_reg(`REG_CTRL, 16'h0020 << i);
      fault(i);
      see(8, 1'b0);
      see(40, 1'b1);
    end
    wr_reg(`REG_CTRL, 16'h01E0);
    fault(4);
    see(40, 1'b0);
    flag_chk(0, 1'b1);
    man_rst(1'b1);
    flag_chk(0, 1'b0);
    wr_reg(`REG_AR_DELAY, 16'h0000);
    wr_reg(`REG_CTRL, 16'h0020);
    wr_reg(`REG_IRQ_MASK, 16'h0004);
    // Autoresets and the blocked spell above left their sticky bits.
    rd_chk(`REG_IRQ_STAT, 16'h000C);
    fault(0);
    see(4, 1'b1);
    flag_chk(2, 1'b1);
    rd_chk(`REG_IRQ_STAT, 16'h0004);
    flag_chk(2, 1'b0);
    wr_reg(`REG_IRQ_MASK, 16'h0000);
    fault(0);
    see(4, 1'b1);
    flag_chk(2, 1'b0);
    rd_chk(`REG_IRQ_STAT, 16'h0004);
    wr_reg(`REG_UL_TIME, 16'h0003);
    wr_reg(`REG_CTRL, 16'h000E);
    motor_torque <= 16'h0032;
    repeat (25) @(posedge clk);
    flag_chk(1, 1'b0);
    repeat (30) @(posedge clk);
    flag_chk(1, 1'b1);
    ul_run(16'h000E, 16'h012C, 16'h0032, 2'h1);
    ul_run(16'h000D, 16'h012C, 16'h0032, 2'h2);
    ul_run(16'h000C, 16'h012C, 16'h0032, 2'h0);
    ul_run(16'h000E, 16'h012C, 16'h0096, 2'h0);
    ul_run(16'h000E, 16'h0032, 16'h0032, 2'h0);
    ul_run(16'h0012, 16'h012C, 16'h0096, 2'h1);
    ul_run(16'h0002, 16'h01F4, 16'h0096, 2'h0);
    ul_run(16'h0006, 16'h01F4, 16'h0096, 2'h1);
    ul_run(16'h000A, 16'h01F4, 16'h00FA, 2'h1);
    wr_reg(`REG_RATED_FREQ, 16'h03E8);
    ul_run(16'h000E, 16'h0050, 16'h0032, 2'h0);
    ul_run(16'h000E, 16'h0078, 16'h0032, 2'h1);
    // Below rated frequency curve 2 ramps: 300 * 12 Hz / 100 Hz is 36.
    ul_run(16'h000A, 16'h0078, 16'h0032, 2'h0);
    ul_run(16'h000A, 16'h0078, 16'h0014, 2'h1);
    print_verdict();
  end
endmodule
bind underload_autoreset ul_ar_checker u_chk (.clk, .nrst, .addr, .wdata,
  .wr, .rd, .rdata, .output_frequency, .fault_other, .panel_reset_pin,
  .ext_reset_pin, .drive_tripped, .coast_stop, .underload_warning,
  .autoreset_pulse);
`default_nettype wire
